// ---- core/ogac_pkg.sv ----
// Purpose: Shared constants and types for the gate and alert control block
// Assumes: 250 MHz logic clock, SMBus slave pins sampled on that clock
// Notes: Status bit positions follow the status word layout
package ogac_pkg;
    localparam int CLK_MHZ = 250;
    localparam int POR_TIMEOUT_MS = 25;
    localparam int POR_TIMEOUT_CYC = POR_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam logic [6:0] OWN_ADDR = 7'h47;
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [7:0] ARA_REPLY = 8'h8f;
    localparam int ST_DIS_OC = 7;
    localparam int ST_CHG_OC = 6;
    localparam int ST_DIRCHG = 1;
    localparam int ST_SOFT = 3;
    localparam logic [15:0] STATUS_FILL = 16'hff01;

    typedef struct packed {
        logic force_off;
        logic force_on;
    } ogac_force_s;

    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } ogac_pin_s;

    typedef enum logic [2:0] {
        SL_IDLE,
        SL_ADDR,
        SL_ACK,
        SL_SEND,
        SL_RACK,
        SL_SKIP
    } ogac_slave_e;
endpackage

// ---- core/ogac_sync2.sv ----
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Input is asynchronous to clk
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module ogac_sync2 #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // ogac_sync2

// ---- core/ogac_top.sv ----
// Purpose: Gate drivers, alert pin, reset output and ARA responder
// Assumes: Analog thresholds and comparators arrive as digital levels
// Notes: Only the alert-response read is decoded on the serial port
//
// What this block does
// R1 - Both force bits clear: gate low unless overcurrent flag set, then released.
// R2 - Force-off only releases the gate; force-on only drives it low.
// R3 - Both force bits set: gate follows the comparator directly.
// R4 - Any overcurrent raises the alert regardless of force bits.
// R5 - Alert stays asserted across later crossings until cleared.
// R6 - Both gates released during the reset timeout.
// R7 - Compare and direction events alert only when enabled.
// R8 - Alert clears on clear bit, ARA acknowledge, or power-on reset.
// R9 - ARA read while pending gets acknowledged with reply 0x8F.
// R10 - Host reads ARA 0001100 to find the alerting device.
// R11 - Alert pin is open-drain and active low.
// R12 - Reset output low at power-up, hard shutdown, or regulator low.
// R13 - Reset output held low 25 ms after regulator rises above upper threshold.
// R14 - Shutdown pin low forces reset state and releases both gates.
// R15 - Soft shutdown bit clears all pending interrupts.
// R16 - Host should enter soft shutdown with both force-off bits set.
// R17 - Leaving soft shutdown causes no reset; settings kept.
// R18 - Serial port acts as slave only, never starts transfers.
// R19 - Fixed slave address 0b1000111, bytes 0x8E and 0x8F; code decodes neither, 0x8F only goes out as the ARA reply.
// R20 - Overcurrent latches stay set until clear bit, soft shutdown, or reset.
// R21 - Discharge flag at status bit 7, charge flag at bit 6.
// R22 - Direction change with its enable set asserts the alert.
// R23 - Comparators pass two flip-flops before latches; free-run gate reads the same synchronised level.
// R24 - Reset timeout counter restarts whenever upper threshold drops.
`timescale 1ns/1ps
module ogac_top #(
    parameter int POR_CYCLES = ogac_pkg::POR_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Configuration bits
    input wire logic charge_force_off_bit,
    input wire logic charge_force_on_bit,
    input wire logic discharge_force_off_bit,
    input wire logic discharge_force_on_bit,
    input wire logic clear_interrupt_bit,
    input wire logic soft_shutdown_bit,
    input wire logic direction_irq_enable,
    input wire logic compare_irq_enable,
    // Events from the rest of the gauge
    input wire logic compare_match_flag,
    input wire logic direction_change_flag,
    // Analog levels
    input wire logic charge_comparator_result,
    input wire logic discharge_comparator_result,
    input wire logic regulator_low_threshold,
    input wire logic regulator_high_threshold,
    input wire logic hard_shutdown_in_n,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Gate drivers, open drain
    output logic charge_gate_out,
    output logic charge_gate_oe,
    output logic discharge_gate_out,
    output logic discharge_gate_oe,
    // Alert and reset outputs, open drain
    output logic alert_n_out,
    output logic alert_n_oe,
    output logic reset_n_out,
    output logic reset_n_oe,
    // Status
    output logic [15:0] status_word,
    output logic charge_overcurrent_flag,
    output logic discharge_overcurrent_flag
);
    import ogac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic chg_cmp_s, dis_cmp_s, vlow_s, vhigh_s, hard_shutdown_in_n_n_s, scl_s, sda_s;

    ogac_sync2 #(.INIT(1'b0)) u_chg (.clk(sys_clk), .rstn(rstn),
        .d(charge_comparator_result), .q(chg_cmp_s)); // [R23]
    ogac_sync2 #(.INIT(1'b0)) u_dis (.clk(sys_clk), .rstn(rstn),
        .d(discharge_comparator_result), .q(dis_cmp_s)); // [R23]
    ogac_sync2 #(.INIT(1'b0)) u_vlo (.clk(sys_clk), .rstn(rstn),
        .d(regulator_low_threshold), .q(vlow_s));
    ogac_sync2 #(.INIT(1'b0)) u_vhi (.clk(sys_clk), .rstn(rstn),
        .d(regulator_high_threshold), .q(vhigh_s));
    ogac_sync2 #(.INIT(1'b0)) u_shd (.clk(sys_clk), .rstn(rstn),
        .d(hard_shutdown_in_n), .q(hard_shutdown_in_n_n_s));
    ogac_sync2 #(.INIT(1'b1)) u_scl (.clk(sys_clk), .rstn(rstn),
        .d(scl_in), .q(scl_s));
    ogac_sync2 #(.INIT(1'b1)) u_sda (.clk(sys_clk), .rstn(rstn),
        .d(sda_in), .q(sda_s));

    ////////////////////////////////////////////////////////////////////////////
    // Power-on reset and timeout
    // Internal reset: regulator low or hard shutdown forces the full reset state
    logic por_force;
    logic por_active;
    logic [31:0] por_cnt;

    assign por_force = !vlow_s || !hard_shutdown_in_n_n_s; // [R12] [R14]

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            por_cnt <= 32'h0000_0000;
            por_active <= 1'b1;
        end else if (por_force || !vhigh_s) begin
            por_cnt <= 32'h0000_0000; // [R24]
            por_active <= 1'b1;
        end else if (por_active) begin
            if (por_cnt >= 32'(POR_CYCLES - 1)) begin
                por_active <= 1'b0; // [R13]
            end
            por_cnt <= por_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reset_n_out <= 1'b0;
            reset_n_oe <= 1'b1;
        end else begin
            reset_n_out <= 1'b0;
            reset_n_oe <= por_active; // [R12] [R13] [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial port edge detection
    logic scl_d, sda_d;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Alert-response slave, never drives the bus unless addressed
    ogac_slave_e st;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic ara_ack;
    logic alert_pending;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= SL_IDLE;
            shreg <= 8'h00;
            bitn <= 4'h0;
            ara_ack <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            ara_ack <= 1'b0;
            if (por_force || stop_cond) begin
                st <= SL_IDLE;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                st <= SL_ADDR; // [R18]
                bitn <= 4'h0;
                sda_oe <= 1'b0;
            end else begin
                unique case (st)
                    SL_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    SL_ADDR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_s};
                            bitn <= bitn + 4'h1;
                        end else if (scl_fall && bitn == 4'h8) begin
                            // Only an ARA read while pending is answered
                            if (shreg == {ARA_ADDR, 1'b1} && alert_pending) begin
                                st <= SL_ACK; // [R9]
                                sda_oe <= 1'b1;
                            end else begin
                                st <= SL_SKIP;
                            end
                        end
                    end
                    SL_ACK: begin
                        if (scl_fall) begin
                            st <= SL_SEND;
                            shreg <= ARA_REPLY; // [R9] [R19]
                            sda_oe <= !ARA_REPLY[7];
                            bitn <= 4'h0;
                            ara_ack <= 1'b1; // [R8]
                        end
                    end
                    SL_SEND: begin
                        if (scl_fall) begin
                            if (bitn == 4'h7) begin
                                st <= SL_RACK;
                                sda_oe <= 1'b0;
                            end else begin
                                shreg <= {shreg[6:0], 1'b0};
                                sda_oe <= !shreg[6];
                                bitn <= bitn + 4'h1;
                            end
                        end
                    end
                    SL_RACK: begin
                        if (scl_fall) begin
                            st <= SL_SKIP;
                        end
                    end
                    SL_SKIP: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overcurrent and direction latches
    logic chg_oc, dis_oc, dir_latch;
    logic clr_d, clr_pulse;
    logic latch_clear;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clr_d <= 1'b0;
        end else begin
            clr_d <= clear_interrupt_bit;
        end
    end

    // Writing a 1 is seen as the rising edge of the clear bit
    assign clr_pulse = clear_interrupt_bit && !clr_d;
    assign latch_clear = clr_pulse || soft_shutdown_bit || por_force; // [R20] [R15]

    // Set wins over clear so an event on the clear cycle survives
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chg_oc <= 1'b0;
            dis_oc <= 1'b0;
            dir_latch <= 1'b0;
        end else begin
            chg_oc <= (chg_cmp_s && !soft_shutdown_bit && !por_force)
                || (chg_oc && !latch_clear); // [R20]
            dis_oc <= (dis_cmp_s && !soft_shutdown_bit && !por_force)
                || (dis_oc && !latch_clear); // [R20]
            dir_latch <= (direction_change_flag && !soft_shutdown_bit && !por_force)
                || (dir_latch && !latch_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert
    logic alert_set;

    // Events, not latch levels, set the alert, so an ARA clear is not undone
    assign alert_set = chg_cmp_s || dis_cmp_s // [R4]
        || (compare_match_flag && compare_irq_enable) // [R7]
        || (direction_change_flag && direction_irq_enable); // [R22]

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            alert_pending <= 1'b0;
        end else if (por_force || soft_shutdown_bit) begin
            alert_pending <= 1'b0; // [R8] [R15]
        end else if (alert_set) begin
            alert_pending <= 1'b1; // [R5]
        end else if (clr_pulse || ara_ack) begin
            alert_pending <= 1'b0; // [R8]
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            alert_n_out <= 1'b0;
            alert_n_oe <= 1'b0;
        end else begin
            alert_n_out <= 1'b0;
            alert_n_oe <= alert_pending; // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate drivers: oe high pulls low (path on), oe low is high-impedance (off)
    ogac_force_s chg_f, dis_f;

    assign chg_f = '{force_off: charge_force_off_bit, force_on: charge_force_on_bit};
    assign dis_f = '{force_off: discharge_force_off_bit, force_on: discharge_force_on_bit};

    function automatic logic gate_drive(ogac_force_s f, logic flag, logic cmp);
        logic r;
        r = 1'b0;
        unique case ({f.force_off, f.force_on})
            2'b00: r = !flag; // [R1]
            2'b01: r = 1'b1; // [R2]
            2'b10: r = 1'b0; // [R2]
            2'b11: r = !cmp; // [R3]
        endcase
        return r;
    endfunction

    // Free-run reads the synchronised comparator: two cycles slower, never metastable
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            charge_gate_out <= 1'b0;
            charge_gate_oe <= 1'b0;
            discharge_gate_out <= 1'b0;
            discharge_gate_oe <= 1'b0;
        end else begin
            charge_gate_out <= 1'b0;
            discharge_gate_out <= 1'b0;
            charge_gate_oe <= !por_active
                && gate_drive(chg_f, chg_oc, chg_cmp_s); // [R6] [R14] [R23]
            discharge_gate_oe <= !por_active
                && gate_drive(dis_f, dis_oc, dis_cmp_s); // [R6] [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_word <= STATUS_FILL;
            charge_overcurrent_flag <= 1'b0;
            discharge_overcurrent_flag <= 1'b0;
        end else begin
            status_word <= STATUS_FILL;
            status_word[ST_DIS_OC] <= dis_oc; // [R21]
            status_word[ST_CHG_OC] <= chg_oc; // [R21]
            status_word[ST_DIRCHG] <= dir_latch;
            status_word[ST_SOFT] <= soft_shutdown_bit; // [R17]
            charge_overcurrent_flag <= chg_oc;
            discharge_overcurrent_flag <= dis_oc;
        end
    end
endmodule // ogac_top

// ---- dv/ogac_top_properties.sv ----
// Purpose: Assertions on the gate, alert and reset pins of ogac_top
// Assumes: Config bits held steady a few cycles before they are judged
// Notes: Windows allow for the two-stage input synchronisers
`timescale 1ns/1ps
module ogac_top_properties #(
    parameter int POR_CYCLES = 50
) (
    // Clock, reset, configuration
    input wire logic sys_clk, rstn,
    input wire logic charge_force_off_bit, charge_force_on_bit,
    input wire logic clear_interrupt_bit, soft_shutdown_bit, hard_shutdown_in_n,
    input wire logic charge_comparator_result,
    input wire logic regulator_low_threshold, regulator_high_threshold,
    // Pins and status
    input wire logic sda_out, charge_gate_out, discharge_gate_out, alert_n_out, reset_n_out,
    input wire logic charge_gate_oe, discharge_gate_oe, alert_n_oe, reset_n_oe,
    input wire logic [15:0] status_word,
    input wire logic charge_overcurrent_flag, discharge_overcurrent_flag
);
    int supply_cnt;
    logic live;
    logic quiet;
    assign live = !reset_n_oe && hard_shutdown_in_n;
    assign quiet = live && !clear_interrupt_bit && !soft_shutdown_bit;
    // Cycles spent in reset with every supply indication good
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            supply_cnt <= 0;
        end else if (reset_n_oe && regulator_low_threshold && regulator_high_threshold
                     && hard_shutdown_in_n) begin
            supply_cnt <= supply_cnt + 1;
        end else begin
            supply_cnt <= 0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_pins_open_drain:
        assert property (!sda_out && !charge_gate_out && !discharge_gate_out
            && !alert_n_out && !reset_n_out) else $error("pin driven high");
    chk_auto_gate:
        assert property ((live && !charge_force_off_bit && !charge_force_on_bit)[*5]
            ##0 $stable(charge_overcurrent_flag) |-> charge_gate_oe == !charge_overcurrent_flag)
            else $error("auto gate wrong");
    chk_force_on_gate:
        assert property ((live && !charge_force_off_bit && charge_force_on_bit)[*5]
            |-> charge_gate_oe) else $error("forced-on gate released");
    chk_force_off_gate:
        assert property ((live && charge_force_off_bit && !charge_force_on_bit)[*5]
            |-> !charge_gate_oe) else $error("forced-off gate driven");
    chk_free_run_gate:
        assert property ((live && charge_force_off_bit && charge_force_on_bit)[*5]
            |=> charge_gate_oe == !$past(charge_comparator_result, 3))
            else $error("free-run gate wrong");
    chk_por_gates:
        assert property (reset_n_oe && $past(reset_n_oe) |-> !charge_gate_oe
            && !discharge_gate_oe) else $error("gate on during reset");
    chk_hard_stop:
        assert property ((!hard_shutdown_in_n)[*5] |-> reset_n_oe && !charge_gate_oe
            && !discharge_gate_oe) else $error("hard shutdown ignored");
    chk_por_too_short:
        assert property ($fell(reset_n_oe) |-> supply_cnt >= POR_CYCLES)
            else $error("reset released early");
    chk_por_too_long:
        assert property (supply_cnt <= POR_CYCLES + 8) else $error("reset held too long");
    chk_latch_hold:
        assert property (quiet[*5] ##0 charge_overcurrent_flag |=> charge_overcurrent_flag)
            else $error("latch dropped");
    chk_alert_raise:
        assert property ($rose(charge_overcurrent_flag) && quiet |-> ##[0:2] alert_n_oe)
            else $error("alert not raised");
    chk_soft_clears:
        assert property (soft_shutdown_bit[*6] |-> !charge_overcurrent_flag
            && !discharge_overcurrent_flag && !alert_n_oe) else $error("soft not clear");
    chk_status_map:
        assert property ($stable(charge_overcurrent_flag) && $stable(discharge_overcurrent_flag)
            |-> status_word[15:8] == 8'hff && status_word[0]
            && status_word[7] == discharge_overcurrent_flag
            && status_word[6] == charge_overcurrent_flag) else $error("status map wrong");
endmodule // ogac_top_properties

bind ogac_top ogac_top_properties #(.POR_CYCLES(POR_CYCLES)) chk_u (.*);

// ---- dv/ogac_host_model.sv ----
// Purpose: Host side of the serial port, master of receive-byte reads
// Assumes: Open-drain lines with pull-ups, 32 ns serial clock
// Notes: Clock stands high between frames
`timescale 1ns/1ps
module ogac_host_model (
    // Resolved data line
    input wire logic sda_line,
    // Driven lines
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic read_byte(input logic [6:0] adr, output logic ack, output logic [7:0] d);
        logic [7:0] a;
        a = {adr, 1'b1};
        sda_low = 1'b1;
        #16 scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #8 sda_low = !a[i];
            #8 scl = 1'b1;
            #16 scl = 1'b0;
        end
        #8 sda_low = 1'b0;
        #8 scl = 1'b1;
        #8 ack = !sda_line;
        #8 scl = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #16 scl = 1'b1;
            #8 d[i] = sda_line;
            #8 scl = 1'b0;
        end
        // Released line is the closing not-acknowledge
        #16 scl = 1'b1;
        #16 scl = 1'b0;
        #8 sda_low = 1'b1;
        #8 scl = 1'b1;
        #8 sda_low = 1'b0;
    endtask
endmodule // ogac_host_model

// ---- dv/ogac_top_tb.sv ----
// Purpose: Self-checking bench for ogac_top
// Assumes: Short reset timeout parameter
// Notes: Host model runs the serial port
`timescale 1ns/1ps
module ogac_top_tb;
    import ogac_pkg::*;
    localparam int POR = 50;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic charge_force_off_bit, charge_force_on_bit, discharge_force_off_bit;
    logic discharge_force_on_bit, clear_interrupt_bit, soft_shutdown_bit;
    logic direction_irq_enable, compare_irq_enable, compare_match_flag, direction_change_flag;
    logic charge_comparator_result, discharge_comparator_result, hard_shutdown_in_n;
    logic regulator_low_threshold, regulator_high_threshold;
    logic sda_out, sda_oe, charge_gate_out, charge_gate_oe, discharge_gate_out;
    logic discharge_gate_oe, alert_n_out, alert_n_oe, reset_n_out, reset_n_oe;
    logic charge_overcurrent_flag, discharge_overcurrent_flag;
    logic [15:0] status_word;
    logic scl, sda_low, sda_line;
    int errors = 0;
    int total_checks = 0;
    // Pull-up on the data line
    assign sda_line = !(sda_low || sda_oe);
    ogac_top #(.POR_CYCLES(POR)) dut_u (.*, .scl_in(scl), .sda_in(sda_line));
    ogac_host_model host_u (.sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop;
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic set_force(input logic [3:0] f);
        @(posedge sys_clk);
        {charge_force_off_bit, charge_force_on_bit, discharge_force_off_bit,
         discharge_force_on_bit} <= f;
    endtask
    task automatic comp(input logic [1:0] v, input int n);
        @(posedge sys_clk);
        {discharge_comparator_result, charge_comparator_result} <= v;
        cyc(n);
    endtask
    task automatic clr;
        @(posedge sys_clk);
        clear_interrupt_bit <= 1'b1;
        cyc(6);
        @(posedge sys_clk);
        clear_interrupt_bit <= 1'b0;
        cyc(6);
        chk("alert after clear", alert_n_oe, 1'b0);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_por(input bit hard);
        @(posedge sys_clk);
        if (hard) hard_shutdown_in_n <= 1'b0;
        cyc(8);
        chk("reset out", reset_n_oe, 1'b1);
        chk("gates in reset", {discharge_gate_oe, charge_gate_oe}, 2'b00);
        @(posedge sys_clk);
        hard_shutdown_in_n <= 1'b1;
        regulator_low_threshold <= 1'b1;
        regulator_high_threshold <= 1'b1;
        cyc(POR - 5);
        chk("reset held", reset_n_oe, 1'b1);
        cyc(15);
        chk("reset released", reset_n_oe, 1'b0);
    endtask
    task automatic t_gate_table;
        for (int f = 0; f < 4; f++) begin
            set_force({f[1:0], f[1:0]});
            cyc(6);
            chk("gates", {discharge_gate_oe, charge_gate_oe}, f != 2 ? 2'b11 : 2'b00);
        end
    endtask
    task automatic t_latch;
        for (int p = 0; p < 2; p++) begin
            set_force(p ? 4'h5 : 4'h0);
            comp(2'(1 << p), 8);
            comp(2'b00, 8);
            chk("flags", {discharge_overcurrent_flag, charge_overcurrent_flag}, 16'(1 << p));
            chk("status", status_word[7:6], 16'(1 << p));
            chk("alert", alert_n_oe, 1'b1);
            chk("gates", {discharge_gate_oe, charge_gate_oe}, p ? 2'b11 : 2'b10);
            clr;
            chk("flags clear", {discharge_overcurrent_flag, charge_overcurrent_flag}, 2'b00);
        end
    endtask
    task automatic t_free_run;
        set_force(4'hf);
        comp(2'b11, 3);
        chk("free gates off", {discharge_gate_oe, charge_gate_oe}, 2'b00);
        comp(2'b00, 3);
        chk("free gates on", {discharge_gate_oe, charge_gate_oe}, 2'b11);
        comp(2'b01, 3);
        comp(2'b00, 8);
        chk("alert kept", alert_n_oe, 1'b1);
        clr;
    endtask
    task automatic t_events;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            compare_irq_enable <= (k == 1);
            direction_irq_enable <= (k == 2);
            compare_match_flag <= 1'b1;
            direction_change_flag <= 1'b1;
            cyc(4);
            @(posedge sys_clk);
            compare_match_flag <= 1'b0;
            direction_change_flag <= 1'b0;
            cyc(8);
            chk("event alert", alert_n_oe, k != 0);
            chk("direction status", status_word[1], 1'b1);
            clr;
        end
    endtask
    task automatic t_ara;
        logic ack;
        logic [7:0] d;
        set_force(4'h0);
        host_u.read_byte(ARA_ADDR, ack, d);
        chk("idle ara ack", ack, 1'b0);
        comp(2'b01, 8);
        comp(2'b00, 2);
        host_u.read_byte(ARA_ADDR, ack, d);
        cyc(4);
        chk("ara ack", ack, 1'b1);
        chk("ara reply", d, ARA_REPLY);
        chk("alert after ara", alert_n_oe, 1'b0);
        chk("data released", sda_oe, 1'b0);
        clr;
    endtask
    task automatic t_soft;
        comp(2'b10, 8);
        comp(2'b00, 2);
        set_force(4'ha);
        @(posedge sys_clk);
        soft_shutdown_bit <= 1'b1;
        cyc(8);
        chk("soft flags", {discharge_overcurrent_flag, charge_overcurrent_flag, alert_n_oe}, 3'b000);
        chk("soft status", status_word[3], 1'b1);
        chk("soft gates", {discharge_gate_oe, charge_gate_oe}, 2'b00);
        @(posedge sys_clk);
        soft_shutdown_bit <= 1'b0;
        cyc(8);
        chk("no reset on exit", reset_n_oe, 1'b0);
        chk("config kept", {discharge_gate_oe, charge_gate_oe}, 2'b00);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        {charge_force_off_bit, charge_force_on_bit, discharge_force_off_bit} = 3'b000;
        {discharge_force_on_bit, clear_interrupt_bit, soft_shutdown_bit} = 3'b000;
        {direction_irq_enable, compare_irq_enable, compare_match_flag} = 3'b000;
        {direction_change_flag, charge_comparator_result, discharge_comparator_result} = 3'b000;
        {regulator_low_threshold, regulator_high_threshold} = 2'b00;
        hard_shutdown_in_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        t_por(1'b0);
        t_gate_table();
        t_latch();
        t_free_run();
        t_events();
        t_ara();
        t_soft();
        set_force(4'h5);
        t_por(1'b1);
        report_and_stop();
    end
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
endmodule // ogac_top_tb
